/* File: src/sfp_pkg.sv */
// Shared constants and types for the parallel FIFO host port.
package sfp_pkg;

    // Widths of the pin groups.
    localparam int DATA_W = 16;
    localparam int SEL_W = 3;
    localparam int LEN_W = 16;

    // Depth of each endpoint buffer in words.
    localparam int FIFO_DEPTH = 8;

    // Values of the FIFO select lines that reach the two endpoint buffers.
    localparam logic [SEL_W-1:0] SEL_IN_EP = 3'h0;
    localparam logic [SEL_W-1:0] SEL_OUT_EP = 3'h2;

    // Reset values.
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_RESET = 16'h0000;

    // Latency of the pin synchronisers in system clock cycles.
    localparam int SYNC_STAGES = 2;

    // Pin group as seen by the synchroniser chain.
    typedef struct packed {
        logic iclk;
        logic [SEL_W-1:0] sel;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic oe_n;
        logic commit;
        logic [DATA_W-1:0] data;
    } sfp_pins_type;

    // Packet commit notice towards the USB side.
    typedef struct packed {
        logic valid;
        logic [LEN_W-1:0] len;
    } sfp_commit_type;

endpackage

/* File: src/sfp_host_port.sv */
// Parallel FIFO host port with its endpoint buffers.

// Buffer with valid and ready on both sides; storage is flip-flops.
module sfp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sfp_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] ONE_CNT = (PTR_W + 1)'(1);

    // Storage, pointers, registered flags and the registered head word.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic [PTR_W:0] count_next;
    logic not_full_reg;
    logic not_empty_reg;
    logic push;
    logic pop;
    logic [PTR_W-1:0] rd_ptr_inc;
    logic [WIDTH-1:0] head_reg;

    assign push = in_valid & not_full_reg;
    assign pop = out_ready & not_empty_reg;
    assign in_ready = not_full_reg;
    assign out_valid = not_empty_reg;
    assign out_data = head_reg;
    assign rd_ptr_inc = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;

    // Occupancy after this cycle's push and pop.
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Flags are registered so that neither side sees a combinational path.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            not_full_reg <= 1'b1;
            not_empty_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            not_full_reg <= (count_next != DEPTH_CNT);
            not_empty_reg <= (count_next != '0);
        end
    end

    // Storage needs no reset; a slot read before it is written only reaches the head register while the buffer is empty.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // The head word sits in its own register, so the drain side sees a flop, not a mux.
    // A push into a buffer that is empty, or emptying this cycle, bypasses storage.
    always_ff @(posedge clk) begin
        if (push && (count_reg == '0 || (pop && count_reg == ONE_CNT))) begin
            head_reg <= in_data;
        end else if (pop) begin
            head_reg <= mem_reg[rd_ptr_inc];
        end
    end
endmodule

// Device end of the port: master writes the IN buffer and reads the OUT buffer.
module sfp_host_port #(
    parameter int DEPTH = sfp_pkg::FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SYNC_MODE,
    input wire logic AUTO_MODE,
    input wire logic [sfp_pkg::LEN_W-1:0] AUTO_COMMIT_LENGTH,
    input wire logic INTERFACE_CLOCK,
    input wire logic [sfp_pkg::SEL_W-1:0] FIFO_SELECT,
    input wire logic FIFO_CHIP_SELECT_N,
    input wire logic FIFO_READ_STROBE_N,
    input wire logic FIFO_WRITE_STROBE_N,
    input wire logic FIFO_OUTPUT_ENABLE_N,
    input wire logic PACKET_COMMIT_STROBE,
    input wire logic [sfp_pkg::DATA_W-1:0] FIFO_DATA_IN,
    output logic [sfp_pkg::DATA_W-1:0] FIFO_DATA_OUT,
    output logic FIFO_DATA_OE_N,
    output logic FLAG_EMPTY,
    output logic FLAG_FULL,
    output logic USB_IN_VALID,
    input wire logic USB_IN_READY,
    output logic [sfp_pkg::DATA_W-1:0] USB_IN_DATA,
    output sfp_pkg::sfp_commit_type USB_IN_COMMIT,
    input wire logic USB_OUT_VALID,
    output logic USB_OUT_READY,
    input wire logic [sfp_pkg::DATA_W-1:0] USB_OUT_DATA
);
    import sfp_pkg::*;

    // Pin bundle as it arrives and at each synchroniser stage.
    sfp_pins_type pins_raw;
    sfp_pins_type pin_s1_reg;
    sfp_pins_type pin_s2_reg;
    sfp_pins_type pin_s3_reg;
    logic iclk_rise;
    logic rd_now;
    logic rd_was;
    logic wr_now;
    logic wr_was;
    logic rd_evt;
    logic wr_evt;
    logic commit_evt;

    // Decoded events and buffer handshakes.
    logic [DATA_W-1:0] wr_word;
    logic sel_in;
    logic sel_out;
    logic in_push;
    logic in_ready;
    logic out_pop;
    logic out_valid;
    logic [DATA_W-1:0] out_head;

    // Packet accounting and registered outputs.
    logic [LEN_W-1:0] pend_reg;
    logic [LEN_W-1:0] pend_plus;
    logic [DATA_W-1:0] dout_reg;
    logic oe_n_reg;
    logic empty_reg;
    logic full_reg;
    sfp_commit_type commit_reg;

    // Idle level of every pin, so that leaving reset raises no false strobe or clock edge.
    localparam sfp_pins_type PINS_IDLE = '{
        iclk: 1'b0,
        sel: '1,
        cs_n: 1'b1,
        rd_n: 1'b1,
        wr_n: 1'b1,
        oe_n: 1'b1,
        commit: 1'b0,
        data: DATA_RESET
    };

    // All pins, the interface clock among them, travel as one bundle.
    assign pins_raw = '{iclk: INTERFACE_CLOCK, sel: FIFO_SELECT, cs_n: FIFO_CHIP_SELECT_N,
                        rd_n: FIFO_READ_STROBE_N, wr_n: FIFO_WRITE_STROBE_N,
                        oe_n: FIFO_OUTPUT_ENABLE_N, commit: PACKET_COMMIT_STROBE,
                        data: FIFO_DATA_IN};

    // Two-stage synchroniser; a third stage serves edge detection and supplies the asynchronous write word.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1_reg <= PINS_IDLE;
            pin_s2_reg <= PINS_IDLE;
            pin_s3_reg <= PINS_IDLE;
        end else begin
            pin_s1_reg <= pins_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Read and write strobes only count together with chip select, which may be tied low.
    assign rd_now = ~pin_s2_reg.cs_n & ~pin_s2_reg.rd_n;
    assign rd_was = ~pin_s3_reg.cs_n & ~pin_s3_reg.rd_n;
    assign wr_now = ~pin_s2_reg.cs_n & ~pin_s2_reg.wr_n;
    assign wr_was = ~pin_s3_reg.cs_n & ~pin_s3_reg.wr_n;
    assign iclk_rise = pin_s2_reg.iclk & ~pin_s3_reg.iclk;

    // Synchronous mode acts on interface clock edges, asynchronous on strobe edges.
    always_comb begin
        if (SYNC_MODE) begin
            rd_evt = iclk_rise & rd_now;
            wr_evt = iclk_rise & wr_now;
            commit_evt = iclk_rise & pin_s2_reg.commit;
            wr_word = pin_s2_reg.data;
        end else begin
            rd_evt = rd_now & ~rd_was;
            wr_evt = wr_was & ~wr_now;
            commit_evt = pin_s2_reg.commit & ~pin_s3_reg.commit;
            wr_word = pin_s3_reg.data;
        end
    end

    // The select lines are assumed steady around strobes and commits.
    assign sel_in = (pin_s2_reg.sel == SEL_IN_EP);
    assign sel_out = (pin_s2_reg.sel == SEL_OUT_EP);

    // A full buffer refuses the word silently; the full flag warns the master.
    assign in_push = wr_evt & sel_in;
    assign out_pop = rd_evt & sel_out & out_valid;
    assign pend_plus = pend_reg + 1'b1;

    sfp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_in_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(in_push),
        .in_ready(in_ready),
        .in_data(wr_word),
        .out_valid(USB_IN_VALID),
        .out_ready(USB_IN_READY),
        .out_data(USB_IN_DATA)
    );

    sfp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_out_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(USB_OUT_VALID),
        .in_ready(USB_OUT_READY),
        .in_data(USB_OUT_DATA),
        .out_valid(out_valid),
        .out_ready(out_pop),
        .out_data(out_head)
    );

    // Packet accounting; auto commit wins, so a strobe on the same edge is lost.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_reg <= LEN_RESET;
            commit_reg <= '{valid: 1'b0, len: LEN_RESET};
        end else begin
            commit_reg.valid <= 1'b0;
            if (in_push && in_ready && AUTO_MODE && pend_plus == AUTO_COMMIT_LENGTH) begin
                pend_reg <= LEN_RESET;
                commit_reg <= '{valid: 1'b1, len: pend_plus};
            end else if (commit_evt && sel_in) begin
                pend_reg <= LEN_RESET;
                commit_reg.valid <= 1'b1;
                commit_reg.len <= (in_push && in_ready) ? pend_plus : pend_reg;
            end else if (in_push && in_ready) begin
                pend_reg <= pend_plus;
            end
        end
    end

    // Read word: prefetched in sync mode, caught at the strobe in async mode.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dout_reg <= DATA_RESET;
        end else if (SYNC_MODE) begin
            // An empty buffer leaves the last word shown rather than an unwritten slot.
            if (sel_out && out_valid) begin
                dout_reg <= out_head;
            end
        end else if (rd_evt && sel_out && out_valid) begin
            dout_reg <= out_head;
        end
    end

    // Bus drive follows output enable and chip select; the device drives only when both are low.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= pin_s2_reg.oe_n | pin_s2_reg.cs_n;
        end
    end

    // Flags track the selected buffer; an unmapped select reads empty and full.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            empty_reg <= 1'b1;
            full_reg <= 1'b1;
        end else if (sel_in) begin
            empty_reg <= ~USB_IN_VALID;
            full_reg <= ~in_ready;
        end else if (sel_out) begin
            empty_reg <= ~out_valid;
            full_reg <= ~USB_OUT_READY;
        end else begin
            // Nothing moves through an unmapped select, so both flags warn the master off.
            empty_reg <= 1'b1;
            full_reg <= 1'b1;
        end
    end

    assign FIFO_DATA_OUT = dout_reg;
    assign FIFO_DATA_OE_N = oe_n_reg;
    assign FLAG_EMPTY = empty_reg;
    assign FLAG_FULL = full_reg;
    assign USB_IN_COMMIT = commit_reg;
endmodule

/* File: bench/sfp_host_port_monitor.sv */
// Concurrent checks on the pins of the FIFO host port.
module sfp_host_port_monitor
    import sfp_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SYNC_MODE,
    input wire logic AUTO_MODE,
    input wire logic [sfp_pkg::SEL_W-1:0] FIFO_SELECT,
    input wire logic FIFO_CHIP_SELECT_N,
    input wire logic FIFO_READ_STROBE_N,
    input wire logic FIFO_WRITE_STROBE_N,
    input wire logic FIFO_OUTPUT_ENABLE_N,
    input wire logic PACKET_COMMIT_STROBE,
    input wire logic [sfp_pkg::DATA_W-1:0] FIFO_DATA_OUT,
    input wire logic FIFO_DATA_OE_N,
    input wire logic FLAG_EMPTY,
    input wire logic FLAG_FULL,
    input wire logic USB_IN_VALID,
    input wire sfp_pkg::sfp_commit_type USB_IN_COMMIT,
    input wire logic USB_OUT_READY
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] wr_age_reg, rd_age_reg, pc_age_reg;

    function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
        return hit ? 4'h0 : a + {3'h0, a != 4'hf};
    endfunction

    // Cycles since each strobe was last active; saturation keeps old strobes from aliasing.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_age_reg <= 4'hf;
            rd_age_reg <= 4'hf;
            pc_age_reg <= 4'hf;
        end else begin
            wr_age_reg <= age(!FIFO_WRITE_STROBE_N && !FIFO_CHIP_SELECT_N, wr_age_reg);
            rd_age_reg <= age(!FIFO_READ_STROBE_N && !FIFO_CHIP_SELECT_N, rd_age_reg);
            pc_age_reg <= age(PACKET_COMMIT_STROBE, pc_age_reg);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // The bus is released once output enable or chip select has been away for a while.
    property p_oe_off; FIFO_OUTPUT_ENABLE_N [*4] |-> FIFO_DATA_OE_N; endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven, enable off");
    property p_cs_off; FIFO_CHIP_SELECT_N [*4] |-> FIFO_DATA_OE_N; endproperty
    a_cs_off: assert property (p_cs_off) else $error("bus driven, not selected");
    // Buffer movements, and commits outside auto mode, must trace back to a recent strobe at the pins; a commit notice lasts one cycle.
    property p_in_push; $rose(USB_IN_VALID) |-> wr_age_reg <= 4'h8; endproperty
    a_in_push: assert property (p_in_push) else $error("word stored without a write");
    property p_out_pop; $rose(USB_OUT_READY) |-> rd_age_reg <= 4'h8; endproperty
    a_out_pop: assert property (p_out_pop) else $error("word popped without a read");
    property p_cm_cause; USB_IN_COMMIT.valid |-> AUTO_MODE || pc_age_reg <= 4'h8; endproperty
    a_cm_cause: assert property (p_cm_cause) else $error("commit without cause");
    property p_cm_pulse; USB_IN_COMMIT.valid |=> !USB_IN_COMMIT.valid; endproperty
    a_cm_pulse: assert property (p_cm_pulse) else $error("commit notice too long");
    // Output enable alone never moves the word shown in asynchronous mode.
    property p_hold; (!SYNC_MODE && FIFO_READ_STROBE_N) [*5] |-> $stable(FIFO_DATA_OUT); endproperty
    a_hold: assert property (p_hold) else $error("word changed without a read");
    property p_unmap;
        (FIFO_SELECT != SEL_IN_EP && FIFO_SELECT != SEL_OUT_EP) [*4] |-> FLAG_EMPTY && FLAG_FULL;
    endproperty
    a_unmap: assert property (p_unmap) else $error("flags wrong for unmapped select");

    c_commit: cover property (USB_IN_COMMIT.valid);
    c_full: cover property (FLAG_FULL && FIFO_SELECT == SEL_IN_EP);
    c_pop: cover property ($rose(USB_OUT_READY));
endmodule

bind sfp_host_port sfp_host_port_monitor u_mon (.CLK(CLK), .SYS_RST(SYS_RST),
    .SYNC_MODE(SYNC_MODE), .AUTO_MODE(AUTO_MODE), .FIFO_SELECT(FIFO_SELECT),
    .FIFO_CHIP_SELECT_N(FIFO_CHIP_SELECT_N), .FIFO_READ_STROBE_N(FIFO_READ_STROBE_N),
    .FIFO_WRITE_STROBE_N(FIFO_WRITE_STROBE_N), .FIFO_OUTPUT_ENABLE_N(FIFO_OUTPUT_ENABLE_N),
    .PACKET_COMMIT_STROBE(PACKET_COMMIT_STROBE), .FIFO_DATA_OUT(FIFO_DATA_OUT),
    .FIFO_DATA_OE_N(FIFO_DATA_OE_N), .FLAG_EMPTY(FLAG_EMPTY), .FLAG_FULL(FLAG_FULL),
    .USB_IN_VALID(USB_IN_VALID), .USB_IN_COMMIT(USB_IN_COMMIT), .USB_OUT_READY(USB_OUT_READY));

/* File: bench/sfp_master_model.sv */
// Behavioural external bus master that drives the FIFO host port pins.
module sfp_master_model
    import sfp_pkg::*;
(
    input wire logic clk,
    input wire logic [sfp_pkg::DATA_W-1:0] bus,
    output logic iclk,
    output logic [sfp_pkg::SEL_W-1:0] sel,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic oe_n,
    output logic commit,
    output logic [sfp_pkg::DATA_W-1:0] mdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pins; the interface clock stands still between frames.
    initial begin
        {iclk, sel, cs_n, rd_n, wr_n, oe_n, commit, mdata} = {1'b0, 3'h7, 4'hf, 1'b0, 16'h0};
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic drive_oe(input logic on);
        @(posedge clk);
        oe_n <= !on;
        step(4);
    endtask

    // One event; in sync mode strobes stay asserted so that calls in a row form a burst, in async mode they are released.
    task automatic xfer(input logic sync, input logic [2:0] s, input logic w, input logic r,
                        input logic c, input logic [15:0] d, output logic [15:0] q);
        if (sel != s || cs_n) begin
            sel <= s;
            cs_n <= 1'b0;
            step(10);
        end
        wr_n <= !w;
        rd_n <= !r;
        commit <= c;
        if (w) mdata <= d;
        step(sync ? 3 : 5);
        @(negedge clk) q = bus;
        @(posedge clk);
        if (sync) begin
            iclk <= 1'b1;
            step(4);
            iclk <= 1'b0;
        end else begin
            {wr_n, rd_n, commit} <= 3'b110;
            step(5);
        end
    endtask

    // Released data lines carry the inverse of the last word, not a held copy.
    task automatic idle();
        {cs_n, rd_n, wr_n, commit} <= 4'b1110;
        mdata <= ~mdata;
        step(6);
    endtask
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the FIFO host port driven by the bus master model.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sfp_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sync_mode = 1'b1;
    logic auto_mode = 1'b0;
    logic [LEN_W-1:0] auto_len = 16'h0004;
    logic in_rdy = 1'b0;
    logic out_vld = 1'b0;
    logic [DATA_W-1:0] out_dat = 16'h0000;
    logic iclk, cs_n, rd_n, wr_n, oe_n, commit, dout_oe_n, flag_e, flag_f, in_vld, out_rdy;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] mdata, dout, in_dat, q;
    wire logic [DATA_W-1:0] bus;
    sfp_commit_type cmt;
    logic [15:0] inq[$], cq[$];
    int miscompares = 0, n_compared = 0, cyc = 0;

    // The wire follows whichever party drives it.
    assign bus = dout_oe_n ? mdata : dout;

    sfp_host_port dut (.CLK(clk), .SYS_RST(rst), .SYNC_MODE(sync_mode), .AUTO_MODE(auto_mode),
        .AUTO_COMMIT_LENGTH(auto_len), .INTERFACE_CLOCK(iclk), .FIFO_SELECT(sel),
        .FIFO_CHIP_SELECT_N(cs_n), .FIFO_READ_STROBE_N(rd_n), .FIFO_WRITE_STROBE_N(wr_n),
        .FIFO_OUTPUT_ENABLE_N(oe_n), .PACKET_COMMIT_STROBE(commit), .FIFO_DATA_IN(bus),
        .FIFO_DATA_OUT(dout), .FIFO_DATA_OE_N(dout_oe_n), .FLAG_EMPTY(flag_e),
        .FLAG_FULL(flag_f), .USB_IN_VALID(in_vld), .USB_IN_READY(in_rdy), .USB_IN_DATA(in_dat),
        .USB_IN_COMMIT(cmt), .USB_OUT_VALID(out_vld), .USB_OUT_READY(out_rdy),
        .USB_OUT_DATA(out_dat));
    sfp_master_model mst (.clk(clk), .bus(bus), .iclk(iclk), .sel(sel), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .oe_n(oe_n), .commit(commit), .mdata(mdata));

    initial begin
        forever #50 clk = ~clk;
    end

    // Records words leaving the IN buffer and packet lengths; a hang is cut short here.
    always @(posedge clk) begin
        if (in_vld === 1'b1 && in_rdy === 1'b1) inq.push_back(in_dat);
        if (cmt.valid === 1'b1) cq.push_back(cmt.len);
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Nine writes into a stalled IN buffer: ninth refused, third commits, a late strobe the rest.
    task automatic t_sync_write();
        for (int i = 0; i < 9; i++) begin
            mst.xfer(1'b1, SEL_IN_EP, 1'b1, 1'b0, i == 2, 16'h1100 + 16'(i), q);
        end
        mst.idle();
        chk("commit length", 16'h0003, cq.pop_front());
        chk("full flag", 16'h0001, {15'h0, flag_f});
        mst.xfer(1'b1, SEL_IN_EP, 1'b0, 1'b0, 1'b1, 16'h0, q);
        mst.idle();
        chk("tail length", 16'h0005, cq.pop_front());
        in_rdy <= 1'b1;
        mst.step(20);
        chk("in count", 16'h0008, 16'(inq.size()));
        for (int i = 0; i < 8; i++) chk("in word", 16'h1100 + 16'(i), inq.pop_front());
        chk("empty flag", 16'h0001, {15'h0, flag_e});
        $display("t_sync_write done");
    endtask

    // Auto commit at four words, then a one-word packet committed by hand on the same event as its write.
    task automatic t_auto();
        auto_mode <= 1'b1;
        for (int i = 0; i < 4; i++) mst.xfer(1'b1, SEL_IN_EP, 1'b1, 1'b0, 1'b0, 16'h2200, q);
        mst.idle();
        mst.xfer(1'b1, SEL_IN_EP, 1'b1, 1'b0, 1'b1, 16'h2204, q);
        mst.idle();
        chk("auto length", 16'h0004, cq.pop_front());
        chk("short length", 16'h0001, cq.pop_front());
        chk("in count", 16'h0005, 16'(inq.size()));
        inq.delete();
        auto_mode <= 1'b0;
        $display("t_auto done");
    endtask

    // OUT buffer filled until it refuses, then a synchronous burst and asynchronous reads.
    task automatic t_read();
        for (int i = 0; i < 8; i++) begin
            out_vld <= 1'b1;
            out_dat <= 16'ha000 + 16'(i);
            do @(posedge clk); while (out_rdy !== 1'b1);
        end
        out_vld <= 1'b0;
        mst.step(4);
        chk("out ready", 16'h0000, {15'h0, out_rdy});
        mst.drive_oe(1'b1);
        for (int i = 0; i < 3; i++) begin
            mst.xfer(1'b1, SEL_OUT_EP, 1'b0, 1'b1, 1'b0, 16'h0, q);
            chk("sync read", 16'ha000 + 16'(i), q);
        end
        mst.idle();
        sync_mode <= 1'b0;
        for (int i = 3; i < 5; i++) begin
            mst.xfer(1'b0, SEL_OUT_EP, 1'b0, 1'b1, 1'b0, 16'h0, q);
            chk("async read", 16'ha000 + 16'(i), q);
        end
        @(negedge clk);
        chk("kept word", 16'ha004, bus);
        mst.drive_oe(1'b0);
        chk("bus released", 16'h0001, {15'h0, dout_oe_n});
        $display("t_read done");
    endtask

    // Asynchronous write, a separate commit strobe, then an unmapped select.
    task automatic t_async_write();
        mst.xfer(1'b0, SEL_IN_EP, 1'b1, 1'b0, 1'b0, 16'h55aa, q);
        mst.xfer(1'b0, SEL_IN_EP, 1'b0, 1'b0, 1'b1, 16'h0, q);
        mst.idle();
        chk("async word", 16'h55aa, inq.pop_front());
        chk("async length", 16'h0001, cq.pop_front());
        mst.xfer(1'b0, 3'h5, 1'b0, 1'b0, 1'b0, 16'h0, q);
        chk("unmapped flags", 16'h0003, {14'h0, flag_e, flag_f});
        $display("t_async_write done");
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        mst.step(4);
        t_sync_write();
        t_auto();
        t_read();
        t_async_write();
        complete_run();
    end
endmodule
